//--- rbfc_top.sv
`timescale 1ns/1ps
`default_nettype none
module rbfc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    input wire rbfc_pkg::rbfc_rx_bit_t rx_bit,
    input wire rbfc_pkg::rbfc_ctrl_t ctrl,
    output logic [7:0] rx_byte,
    output logic rx_byte_valid,
    output logic [2:0] transceive_state,
    output logic cipher_active,
    output logic integrity_error,
    output logic collision_detected,
    output logic irq
);
    import rbfc_pkg::*;
    rbfc_state_t state;
    rbfc_state_t next_state;
    logic [7:0] bit_control;
    logic keep_bits_after_collision;
    logic [2:0] first_bit_position;
    logic collision_as_integrity_error;
    logic [2:0] final_byte_bit_count;
    logic collision_position_valid;
    logic [6:0] collision_position;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_enable;
    logic [IRQ_WIDTH-1:0] irq_event;
    logic [2:0] bit_pos;
    logic [7:0] byte_acc;
    logic [6:0] bit_index;
    logic coll_seen;
    logic bit_oriented;
    logic rx_start;
    logic take_bit;
    logic stored_bit;
    logic coll_event;
    logic frame_done;
    logic [7:0] next_byte;
    logic ahb_active;
    logic dp_write;
    logic dp_read;
    logic [7:0] dp_index;
    logic wr_bit_control;
    logic wr_comm_status;
    logic wr_irq_clear;
    logic wr_irq_enable;
    logic [31:0] read_mux;

    assign keep_bits_after_collision = bit_control[KEEP_BITS_BIT];
    assign first_bit_position = bit_control[FIRST_POS_LSB +: 3];
    assign collision_as_integrity_error = bit_control[COLL_AS_INTEG_BIT];
    assign bit_oriented = (first_bit_position != 3'h0);
    // Receive start: entering wait-for-data, either directly or after transmit
    assign rx_start = (next_state == ST_WAIT_DATA) && (state != ST_WAIT_DATA);

    // Transceive sequencing
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
            begin
                if (ctrl.transceive)
                    next_state = ST_WAIT_TX;
                else if (ctrl.receive)
                    next_state = ST_WAIT_DATA;
            end
            ST_WAIT_TX:
            begin
                if (ctrl.tx_go)
                    next_state = ST_TRANSMITTING;
            end
            ST_TRANSMITTING:
            begin
                if (ctrl.tx_end)
                    next_state = ST_WAIT_RX;
            end
            ST_WAIT_RX:
            begin
                if (ctrl.rx_guard_done)
                    next_state = ST_WAIT_DATA;
            end
            ST_WAIT_DATA:
            begin
                if (ctrl.rx_sof)
                    next_state = ST_RECEIVING;
            end
            ST_RECEIVING:
            begin
                if (ctrl.rx_eof)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
        if (ctrl.stop)
            next_state = ST_IDLE;
    end

    // State register and its reported code; 100b has no state behind it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ST_IDLE;
            transceive_state <= CODE_IDLE;
        end
        else
        begin
            state <= next_state;
            unique case (next_state)
                ST_IDLE: transceive_state <= CODE_IDLE;
                ST_WAIT_TX: transceive_state <= CODE_WAIT_TX;
                ST_TRANSMITTING: transceive_state <= CODE_TRANSMITTING;
                ST_WAIT_RX: transceive_state <= CODE_WAIT_RX;
                ST_WAIT_DATA: transceive_state <= CODE_WAIT_DATA;
                ST_RECEIVING: transceive_state <= CODE_RECEIVING;
                default: transceive_state <= CODE_IDLE;
            endcase
        end
    end

    // Bit handling; bits only count while a frame is being received
    assign take_bit = rx_bit.valid && (state == ST_RECEIVING) && !rx_bit.in_eof;
    assign coll_event = take_bit && rx_bit.collision;
    // Bits after the first collision are blanked; the colliding bit itself is kept
    assign stored_bit = (coll_seen && !keep_bits_after_collision) ? 1'b0 : rx_bit.data;
    assign frame_done = (state == ST_RECEIVING) && ctrl.rx_eof;
    always_comb
    begin
        next_byte = byte_acc;
        next_byte[bit_pos] = stored_bit;
    end

    // Byte assembly and delivery
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bit_pos <= 3'h0;
            byte_acc <= 8'h00;
            rx_byte <= 8'h00;
            rx_byte_valid <= 1'b0;
        end
        else
        begin
            rx_byte_valid <= 1'b0;
            if (rx_start)
            begin
                bit_pos <= first_bit_position;
                byte_acc <= 8'h00;
            end
            else if (take_bit)
            begin
                if (bit_pos == 3'h7)
                begin
                    // Full byte goes out; next bit lands at bit 0 of the next byte
                    rx_byte <= next_byte;
                    rx_byte_valid <= 1'b1;
                    byte_acc <= 8'h00;
                    bit_pos <= 3'h0;
                end
                else
                begin
                    byte_acc <= next_byte;
                    bit_pos <= bit_pos + 3'h1;
                end
            end
            else if (frame_done && (bit_pos != 3'h0))
            begin
                // Partial last byte; unfilled upper bits stay zero
                rx_byte <= byte_acc;
                rx_byte_valid <= 1'b1;
            end
        end
    end

    // Final byte bit count, taken from bit_pos at the end of a bit-oriented frame
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            final_byte_bit_count <= 3'h0;
        else if (rx_start)
            final_byte_bit_count <= 3'h0;
        else if (frame_done && bit_oriented)
            final_byte_bit_count <= bit_pos;
    end

    // Collision position tracking; the index starts at the alignment offset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bit_index <= 7'h00;
            coll_seen <= 1'b0;
            collision_position <= 7'h00;
            collision_position_valid <= 1'b0;
        end
        else if (rx_start)
        begin
            bit_index <= {4'h0, first_bit_position};
            coll_seen <= 1'b0;
            collision_position <= 7'h00;
            collision_position_valid <= 1'b0;
        end
        else if (take_bit)
        begin
            // Saturate so a long frame cannot wrap back into range
            if (bit_index != COLL_RANGE)
                bit_index <= bit_index + 7'h01;
            if (coll_event && !coll_seen)
            begin
                coll_seen <= 1'b1;
                if (bit_index < COLL_RANGE)
                begin
                    collision_position <= bit_index;
                    collision_position_valid <= 1'b1;
                end
            end
        end
    end

    // Error flags; a set in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            integrity_error <= 1'b0;
            collision_detected <= 1'b0;
        end
        else
        begin
            if (irq_event[IRQ_INTEGRITY])
                integrity_error <= 1'b1;
            else if (rx_start)
                integrity_error <= 1'b0;
            if (coll_event)
                collision_detected <= 1'b1;
            else if (rx_start)
                collision_detected <= 1'b0;
        end
    end

    // Cipher flag: authentication sets, software may only clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cipher_active <= 1'b0;
        else if (ctrl.auth_success)
            cipher_active <= 1'b1;
        else if (wr_comm_status && !hwdata[CIPHER_ACTIVE_BIT])
            cipher_active <= 1'b0;
    end

    // AHB-Lite data phase tracking
    assign ahb_active = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wr_bit_control = dp_write && (dp_index == IDX_RECEIVE_BIT_CONTROL);
    assign wr_comm_status = dp_write && (dp_index == IDX_COMM_STATUS);
    assign wr_irq_clear = dp_write && (dp_index == IDX_IRQ_CLEAR);
    assign wr_irq_enable = dp_write && (dp_index == IDX_IRQ_ENABLE);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_index <= 8'h00;
        end
        else
        begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            if (ahb_active)
            begin
                dp_write <= hwrite;
                dp_read <= !hwrite;
                dp_index <= haddr[9:2];
            end
        end
    end

    // Software-writable control bits; the count field below stays hardware-owned
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bit_control <= BIT_CONTROL_RESET;
        else if (wr_bit_control)
            bit_control <= {hwdata[7:3], 3'h0};
    end

    // Read mux; unmapped and reserved bits read zero
    always_comb
    begin
        read_mux = 32'h0000_0000;
        unique case (dp_index)
            IDX_COMM_STATUS:
                read_mux = {26'h0, cipher_active, 2'h0, transceive_state};
            IDX_RECEIVE_BIT_CONTROL:
                read_mux = {24'h0, bit_control[7:3], final_byte_bit_count};
            IDX_RECEIVE_COLLISION_POSITION:
                read_mux = {24'h0, collision_position_valid, collision_position};
            IDX_IRQ_STATUS:
                read_mux = {29'h0, irq_status};
            IDX_IRQ_ENABLE:
                read_mux = {29'h0, irq_enable};
            default:
                read_mux = 32'h0000_0000;
        endcase
    end

    // Reads take one wait state so hrdata can come from a flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
        else
        begin
            hresp <= HRESP_OKAY;
            if (ahb_active && !hwrite)
                hreadyout <= 1'b0;
            else if (dp_read && !hreadyout)
            begin
                hrdata <= read_mux;
                hreadyout <= 1'b1;
            end
        end
    end

    // Interrupt events
    assign irq_event[IRQ_COLLISION] = coll_event;
    assign irq_event[IRQ_INTEGRITY] = (ctrl.integrity_fail && (state == ST_RECEIVING))
                                      || (coll_event && collision_as_integrity_error);
    assign irq_event[IRQ_RX_DONE] = frame_done;

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_status <= IRQ_RESET;
        else if (wr_irq_clear)
            irq_status <= (irq_status & ~hwdata[IRQ_WIDTH-1:0]) | irq_event;
        else
            irq_status <= irq_status | irq_event;
    end

    // Enable register and the interrupt line
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_enable <= IRQ_RESET;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_irq_enable)
                irq_enable <= hwdata[IRQ_WIDTH-1:0];
            // One cycle behind the status bits; kept registered on purpose
            irq <= |(irq_status & irq_enable);
        end
    end

endmodule // rbfc_top
`default_nettype wire

//--- rbfc_pkg.sv
package rbfc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_COMM_STATUS = 8'h0B;
    localparam logic [7:0] IDX_RECEIVE_BIT_CONTROL = 8'h0C;
    localparam logic [7:0] IDX_RECEIVE_COLLISION_POSITION = 8'h0D;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h21;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h22;

    // Field positions
    localparam int CIPHER_ACTIVE_BIT = 5;
    localparam int KEEP_BITS_BIT = 7;
    localparam int FIRST_POS_LSB = 4;
    localparam int COLL_AS_INTEG_BIT = 3;
    localparam int COLL_VALID_BIT = 7;

    // Transceive state codes as reported to software
    localparam logic [2:0] CODE_IDLE = 3'h0;
    localparam logic [2:0] CODE_WAIT_TX = 3'h1;
    localparam logic [2:0] CODE_TRANSMITTING = 3'h3;
    localparam logic [2:0] CODE_WAIT_RX = 3'h5;
    localparam logic [2:0] CODE_WAIT_DATA = 3'h6;
    localparam logic [2:0] CODE_RECEIVING = 3'h7;

    // Collision position range: first eight bytes
    localparam logic [6:0] COLL_RANGE = 7'h40;

    // Interrupt event bits
    localparam int IRQ_COLLISION = 0;
    localparam int IRQ_INTEGRITY = 1;
    localparam int IRQ_RX_DONE = 2;
    localparam int IRQ_WIDTH = 3;

    // Reset values
    localparam logic [7:0] BIT_CONTROL_RESET = 8'h00;
    localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;

    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_WAIT_TX = 6'b000010,
        ST_TRANSMITTING = 6'b000100,
        ST_WAIT_RX = 6'b001000,
        ST_WAIT_DATA = 6'b010000,
        ST_RECEIVING = 6'b100000
    } rbfc_state_t;

    // One decoded bit from the receive decoder
    typedef struct packed {
        logic valid;
        logic data;
        logic collision;
        logic in_eof;
    } rbfc_rx_bit_t;

    // Sequencing events from the command and analog sections
    typedef struct packed {
        logic transceive;
        logic receive;
        logic stop;
        logic tx_go;
        logic tx_end;
        logic rx_guard_done;
        logic rx_sof;
        logic rx_eof;
        logic integrity_fail;
        logic auth_success;
    } rbfc_ctrl_t;

endpackage

//--- rbfc_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rbfc_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire rbfc_pkg::rbfc_rx_bit_t rx_bit,
    input wire rbfc_pkg::rbfc_ctrl_t ctrl,
    input wire logic [2:0] transceive_state,
    input wire logic cipher_active,
    input wire logic integrity_error,
    input wire logic collision_detected
);
    import rbfc_pkg::*;
    logic bus_req;
    logic coll_bit;
    // Taken transfer and a counted colliding data bit
    assign bus_req = hsel && hready && htrans == HTRANS_NONSEQ;
    assign coll_bit = rx_bit.valid && rx_bit.collision && !rx_bit.in_eof;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // State sequencing
    a_state_legal: assert property (transceive_state != 3'h4)
        else $error("state code 4 reported");
    a_rx_enters_wait: assert property (transceive_state == CODE_IDLE && ctrl.receive
        && !ctrl.transceive && !ctrl.stop |=> transceive_state == CODE_WAIT_DATA)
        else $error("receive did not reach wait for data");
    a_stop_to_idle: assert property (ctrl.stop |=> transceive_state == CODE_IDLE)
        else $error("stop did not return to idle");
    // Status flags: set causes and the clear at receive start
    a_cipher_only_auth: assert property ($rose(cipher_active) |-> $past(ctrl.auth_success))
        else $error("cipher flag rose without authentication");
    a_coll_sets_flag: assert property (transceive_state == CODE_RECEIVING && coll_bit
        |=> collision_detected)
        else $error("collision not flagged");
    a_eof_coll_ignored: assert property (!collision_detected && rx_bit.valid && rx_bit.in_eof
        |=> !collision_detected)
        else $error("end-of-frame collision flagged");
    a_integ_fail_sets: assert property (transceive_state == CODE_RECEIVING
        && ctrl.integrity_fail |=> integrity_error)
        else $error("integrity failure not flagged");
    a_flags_clear_rx: assert property ((transceive_state != CODE_WAIT_DATA) ##1
        (transceive_state == CODE_WAIT_DATA) |-> !collision_detected && !integrity_error)
        else $error("flags not cleared at receive start");
    // Bus timing: reads wait one cycle, writes none and answer OKAY
    a_read_one_wait: assert property (bus_req && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (bus_req && hwrite |=> hreadyout && hresp == HRESP_OKAY)
        else $error("write stalled or not OKAY");
    c_frame_end: cover property (transceive_state == CODE_RECEIVING && ctrl.rx_eof);
    c_collision: cover property ($rose(collision_detected));
    c_cipher_on: cover property ($rose(cipher_active));
endmodule // rbfc_checker
`default_nettype wire

//--- rbfc_card.sv
`timescale 1ns/1ps
`default_nettype none
module rbfc_card (
    input wire logic hclk,
    output var rbfc_pkg::rbfc_rx_bit_t rx_bit
);
    import rbfc_pkg::*;
    // Quiet line at time zero
    initial
    begin
        rx_bit = '0;
    end
    // Bits back to back, then an end-of-frame symbol that itself collides;
    // after release the data line flips so a stale value is never trusted
    task automatic send(input logic [79:0] d, input int n, input int ck);
        for (int k = 0; k <= n; k++)
        begin
            @(posedge hclk);
            rx_bit <= '{valid: 1'b1, data: (k < n) ? d[k] : 1'b1,
                        collision: (k == ck || k == n), in_eof: (k == n)};
        end
        @(posedge hclk);
        rx_bit <= '{valid: 1'b0, data: ~rx_bit.data, collision: 1'b0, in_eof: 1'b0};
    endtask
endmodule // rbfc_card
`default_nettype wire

//--- rbfc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rbfc_top_tb;
    import rbfc_pkg::*;
    localparam logic [9:0] EV_TRX = 10'h200;
    localparam logic [9:0] EV_RX = 10'h100;
    localparam logic [9:0] EV_STOP = 10'h080;
    localparam logic [9:0] EV_TX_GO = 10'h040;
    localparam logic [9:0] EV_TX_END = 10'h020;
    localparam logic [9:0] EV_GUARD = 10'h010;
    localparam logic [9:0] EV_SOF = 10'h008;
    localparam logic [9:0] EV_EOF = 10'h004;
    localparam logic [9:0] EV_FAIL = 10'h002;
    localparam logic [9:0] EV_AUTH = 10'h001;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    rbfc_ctrl_t ctrl;
    rbfc_rx_bit_t rx_bit;
    logic [7:0] rx_byte;
    logic rx_byte_valid;
    logic [2:0] transceive_state;
    logic cipher_active;
    logic integrity_error;
    logic collision_detected;
    logic irq;
    logic [7:0] got_q[$];
    int bad_count;
    int compares;
    // The single slave's ready is the bus ready; transfer size is fixed to a word
    rbfc_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .rx_bit(rx_bit), .ctrl(ctrl),
        .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .transceive_state(transceive_state),
        .cipher_active(cipher_active), .integrity_error(integrity_error),
        .collision_detected(collision_detected), .irq(irq)
    );
    rbfc_card u_card (.hclk(hclk), .rx_bit(rx_bit));
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Collect every byte the block hands out
    always @(posedge hclk)
    begin
        if (rx_byte_valid === 1'b1)
            got_q.push_back(rx_byte);
    end
    task automatic report_and_stop();
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for hready high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 40)
        begin
            @(posedge hclk);
            n++;
        end
        if (hreadyout !== 1'b1)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, idx, d, r);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, idx, 32'h0, r);
        check(r, exp);
    endtask
    // One-cycle event pulse; returns where outputs have settled
    task automatic pulse(input logic [9:0] e);
        @(posedge hclk);
        ctrl <= rbfc_ctrl_t'(e);
        @(posedge hclk);
        ctrl <= '0;
        @(negedge hclk);
    endtask
    task automatic s_regs();
        rdchk(IDX_COMM_STATUS, 32'h0);
        rdchk(IDX_RECEIVE_COLLISION_POSITION, 32'h0);
        wr(IDX_RECEIVE_COLLISION_POSITION, 32'hFF);
        rdchk(IDX_RECEIVE_COLLISION_POSITION, 32'h0);
        wr(8'h40, 32'hFF);
        rdchk(8'h40, 32'h0);
        wr(IDX_RECEIVE_BIT_CONTROL, 32'hFFFF_FFFF);
        rdchk(IDX_RECEIVE_BIT_CONTROL, 32'hF8);
    endtask
    // A frame: expected bytes, counts and position worked out bit by bit
    task automatic frame(input logic [7:0] ctl, input logic [79:0] d, input int n,
                         input int ck, input logic fail);
        logic [7:0] exp_q[$];
        logic [7:0] acc;
        int pos;
        int p;
        pos = int'(ctl[6:4]);
        wr(IDX_RECEIVE_BIT_CONTROL, {24'h0, ctl});
        pulse(EV_RX);
        rdchk(IDX_RECEIVE_BIT_CONTROL, {24'h0, ctl[7:3], 3'h0});
        got_q.delete();
        pulse(EV_SOF);
        u_card.send(d, n, ck);
        if (fail)
            pulse(EV_FAIL);
        pulse(EV_EOF);
        repeat (2) @(posedge hclk);
        acc = 8'h0;
        p = pos;
        for (int k = 0; k < n; k++)
        begin
            acc[p] = d[k] && (ck < 0 || k <= ck || ctl[7]);
            p = (p + 1) % 8;
            if (p == 0)
            begin
                exp_q.push_back(acc);
                acc = 8'h0;
            end
        end
        if (p != 0)
            exp_q.push_back(acc);
        check(got_q.size(), exp_q.size());
        foreach (exp_q[i])
            check(got_q[i], exp_q[i]);
        rdchk(IDX_RECEIVE_BIT_CONTROL, {24'h0, ctl[7:3], (pos != 0) ? 3'(p) : 3'h0});
        rdchk(IDX_RECEIVE_COLLISION_POSITION,
              (ck >= 0 && pos + ck < 64) ? 32'h80 + pos + ck : 32'h0);
        check(collision_detected, ck >= 0);
        check(integrity_error, (ck >= 0 && ctl[3]) || fail);
    endtask
    // Masked event stays silent, enabling raises the line, clearing drops it
    task automatic s_irq();
        wr(IDX_IRQ_ENABLE, 32'h0);
        frame(8'h00, 80'h5A, 8, -1, 1'b1);
        check(irq, 1'b0);
        rdchk(IDX_IRQ_STATUS, 32'h6);
        wr(IDX_IRQ_ENABLE, 32'h2);
        repeat (2) @(negedge hclk);
        check(irq, 1'b1);
        wr(IDX_IRQ_CLEAR, 32'h6);
        repeat (2) @(negedge hclk);
        check(irq, 1'b0);
        rdchk(IDX_IRQ_STATUS, 32'h0);
        rdchk(IDX_IRQ_ENABLE, 32'h2);
    endtask
    task automatic s_states();
        logic [9:0] ev[6];
        logic [2:0] code[6];
        ev = '{EV_TRX, EV_TX_GO, EV_TX_END, EV_GUARD, EV_SOF, EV_STOP};
        code = '{CODE_WAIT_TX, CODE_TRANSMITTING, CODE_WAIT_RX, CODE_WAIT_DATA,
                 CODE_RECEIVING, CODE_IDLE};
        for (int i = 0; i < 6; i++)
        begin
            pulse(ev[i]);
            check(transceive_state, code[i]);
            rdchk(IDX_COMM_STATUS, {29'h0, code[i]});
        end
    endtask
    task automatic s_cipher();
        wr(IDX_COMM_STATUS, 32'hFF);
        rdchk(IDX_COMM_STATUS, 32'h0);
        pulse(EV_AUTH);
        rdchk(IDX_COMM_STATUS, 32'h20);
        check(cipher_active, 1'b1);
        wr(IDX_COMM_STATUS, 32'hDF);
        rdchk(IDX_COMM_STATUS, 32'h0);
        check(cipher_active, 1'b0);
    endtask
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ctrl = '0;
        bad_count = 0;
        compares = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        s_regs();
        s_irq();
        s_states();
        s_cipher();
        frame(8'h40, 80'hB, 4, 3, 1'b0);
        frame(8'h70, 80'h3FF, 10, 1, 1'b0);
        frame(8'h88, 80'hC3A5, 16, 0, 1'b0);
        frame(8'h80, 80'h0123_4567_89AB_CDEF, 64, 63, 1'b0);
        frame(8'h00, 80'hFF_0123_4567_89AB_CDEF, 72, 64, 1'b0);
        frame(8'h30, 80'hABC, 12, -1, 1'b0);
        report_and_stop();
    end
endmodule // rbfc_top_tb
bind rbfc_top rbfc_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .rx_bit(rx_bit), .ctrl(ctrl),
    .transceive_state(transceive_state), .cipher_active(cipher_active),
    .integrity_error(integrity_error), .collision_detected(collision_detected)
);
`default_nettype wire
